// ---- hdl/exec_pkg.sv ----
// constants, op codes and carriers for the execute stage
// assumes a decoder upstream and a register file beside it
package exec_pkg;

   // program counter and status word
   localparam int PC_W = 22;
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [PC_W-1:0] PC_RST = 22'h000000;

   // cycle counts per operation and outcome
   localparam logic [1:0] CYC_WORD_ADD = 2'h2;
   localparam logic [1:0] CYC_AND_IMM = 2'h1;
   localparam logic [1:0] CYC_PRODUCT = 2'h2;
   localparam logic [1:0] CYC_NO_SKIP = 2'h1;
   localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
   localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
   localparam logic [1:0] CYC_CALL_SHORT = 2'h2;
   localparam logic [1:0] CYC_CALL_LONG = 2'h3;
   localparam logic [1:0] CYC_BR_NOT = 2'h1;
   localparam logic [1:0] CYC_BR_TAKEN = 2'h2;
   localparam logic [1:0] CYC_OTHER = 2'h1;

   // register port map
   localparam logic [7:0] ADDR_FLAGS = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h01;
   localparam logic [7:0] ADDR_STAT = 8'h02;
   localparam int CTRL_EN = 0;
   localparam logic [7:0] CTRL_RST = 8'h01;

   typedef enum logic [3:0] {
      op_nop,
      word_plus_imm_op,
      and_imm_op,
      signed_unsigned_product_op,
      compare_skip_equal_op,
      indirect_call_op,
      skip_io_bit_clear_op,
      branch_signed_ge_op,
      branch_no_overflow_op
   } exec_op_e;

   typedef struct packed {
      exec_op_e    op;
      logic [7:0]  rd_lo;
      logic [7:0]  rd_hi;
      logic [7:0]  rr;
      logic [7:0]  imm;
      logic [6:0]  rel;
      logic [15:0] z_ptr;
      logic [7:0]  io_val;
      logic [2:0]  io_bit;
      logic        next_two_word;
   } exec_req_s;

   typedef struct packed {
      logic        valid;
      logic        wr_rd;
      logic        wr_pair;
      logic        wr_prod;
      logic [15:0] data;
   } exec_res_s;

endpackage : exec_pkg

// ---- hdl/exec_unit.sv ----
// execute stage: arithmetic, multiply, skip, branch and call ops
// assumes decoded requests with operands already read from the register file
//
// Overview of operation
// [RQ1] word add immediate: pair sum, ZCNVS, 2 cycles
// [RQ2] and immediate: ZNVS only, 1 cycle
// [RQ3] signed-unsigned product into R1:R0, ZC, 2 cycles
// [RQ4] compare equal skips next, flags kept, 1/2/3
// [RQ5] indirect call: push return, PC from Z
// [RQ6] io bit clear skips next, flags kept, 1/2/3
// [RQ7] signed ge branch when N xor V zero
// [RQ8] no overflow branch when V zero, 1/2
// [RQ9] sign flag is N xor V
`timescale 1ns/1ps
`default_nettype none

module exec_unit (
   input  wire logic                    clock,
   input  wire logic                    rst,
   input  wire logic                    req_valid,
   input  wire exec_pkg::exec_req_s     req,
   output logic                         req_ready,
   output exec_pkg::exec_res_s          res,
   output logic [exec_pkg::PC_W-1:0]    pc,
   output logic [7:0]                   flags,
   output logic                         push_valid,
   output logic [exec_pkg::PC_W-1:0]    push_addr,
   input  wire logic [7:0]              reg_addr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic [7:0]                   reg_rdata
);
   import exec_pkg::*;

   ////////////////////////////////////////////////////////////////
   // state
   logic [PC_W-1:0] pc_r;
   logic [PC_W-1:0] pc_nxt;
   logic [7:0]      flags_r;
   logic [7:0]      flags_nxt;
   logic [7:0]      ctrl_r;
   logic [1:0]      left_r;
   logic [1:0]      cyc_nxt;
   logic [1:0]      last_cyc_r;
   exec_res_s       res_r;
   exec_res_s       res_nxt;
   logic            push_r;
   logic            push_nxt;
   logic [PC_W-1:0] push_addr_r;
   logic [7:0]      rdata_r;
   logic            accept;

   ////////////////////////////////////////////////////////////////
   // datapath terms
   logic [15:0]     pair;
   logic [15:0]     pair_sum;
   logic [7:0]      and_res;
   logic [16:0]     prod_full;
   logic [15:0]     prod;
   logic [PC_W-1:0] pc_seq;
   logic [PC_W-1:0] pc_skip;
   logic [PC_W-1:0] pc_rel;
   logic            do_skip;
   logic            io_bit_val;

   assign pair       = {req.rd_hi, req.rd_lo};
   assign pair_sum   = pair + {8'h00, req.imm};
   assign and_res    = req.rd_lo & req.imm;
   assign prod_full  = 17'($signed(req.rd_lo) * $signed({1'b0, req.rr}));
   assign prod       = prod_full[15:0];
   assign pc_seq     = pc_r + 22'h000001;
   assign pc_skip    = req.next_two_word ? pc_r + 22'h000003 : pc_r + 22'h000002;
   assign pc_rel     = pc_seq + {{(PC_W-7){req.rel[6]}}, req.rel};
   assign io_bit_val = req.io_val[req.io_bit];

   assign req_ready = ctrl_r[CTRL_EN] && (left_r == 2'h0);
   assign accept    = req_valid && req_ready;

   ////////////////////////////////////////////////////////////////
   // per-op outcome
   always_comb begin
      pc_nxt    = pc_seq;
      flags_nxt = flags_r;
      cyc_nxt   = CYC_OTHER;
      res_nxt   = '0;
      push_nxt  = 1'b0;
      do_skip   = 1'b0;
      res_nxt.valid = 1'b1;
      unique case (req.op)
         word_plus_imm_op: begin
            res_nxt.wr_pair = 1'b1; // RQ1
            res_nxt.data    = pair_sum; // RQ1
            flags_nxt[FLAG_Z] = (pair_sum == 16'h0000); // RQ1
            flags_nxt[FLAG_C] = ~pair_sum[15] & req.rd_hi[7]; // RQ1
            flags_nxt[FLAG_N] = pair_sum[15]; // RQ1
            flags_nxt[FLAG_V] = ~req.rd_hi[7] & pair_sum[15]; // RQ1
            flags_nxt[FLAG_S] = pair_sum[15] ^ (~req.rd_hi[7] & pair_sum[15]); // RQ9
            cyc_nxt = CYC_WORD_ADD; // RQ1
         end
         and_imm_op: begin
            res_nxt.wr_rd   = 1'b1; // RQ2
            res_nxt.data    = {8'h00, and_res}; // RQ2
            flags_nxt[FLAG_Z] = (and_res == 8'h00); // RQ2
            flags_nxt[FLAG_N] = and_res[7]; // RQ2
            flags_nxt[FLAG_V] = 1'b0; // RQ2
            flags_nxt[FLAG_S] = and_res[7]; // RQ9
            cyc_nxt = CYC_AND_IMM; // RQ2
         end
         signed_unsigned_product_op: begin
            res_nxt.wr_prod = 1'b1; // RQ3
            res_nxt.data    = prod; // RQ3
            flags_nxt[FLAG_Z] = (prod == 16'h0000); // RQ3
            flags_nxt[FLAG_C] = prod[15]; // RQ3
            cyc_nxt = CYC_PRODUCT; // RQ3
         end
         compare_skip_equal_op: begin
            do_skip = (req.rd_lo == req.rr); // RQ4
         end
         skip_io_bit_clear_op: begin
            do_skip = ~io_bit_val; // RQ6
         end
         indirect_call_op: begin
            push_nxt = 1'b1; // RQ5
            pc_nxt   = {{(PC_W-16){1'b0}}, req.z_ptr}; // RQ5
            cyc_nxt  = (PC_W > 16) ? CYC_CALL_LONG : CYC_CALL_SHORT; // RQ5
         end
         branch_signed_ge_op: begin
            cyc_nxt = CYC_BR_NOT; // RQ7
            if ((flags_r[FLAG_N] ^ flags_r[FLAG_V]) == 1'b0) begin
               pc_nxt  = pc_rel; // RQ7
               cyc_nxt = CYC_BR_TAKEN; // RQ7
            end
         end
         branch_no_overflow_op: begin
            cyc_nxt = CYC_BR_NOT; // RQ8
            if (flags_r[FLAG_V] == 1'b0) begin
               pc_nxt  = pc_rel; // RQ8
               cyc_nxt = CYC_BR_TAKEN; // RQ8
            end
         end
         op_nop: begin
            cyc_nxt = CYC_OTHER;
         end
         default: begin
            cyc_nxt = CYC_OTHER;
         end
      endcase
      if (req.op == compare_skip_equal_op || req.op == skip_io_bit_clear_op) begin
         cyc_nxt = CYC_NO_SKIP; // RQ4 RQ6
         if (do_skip) begin
            pc_nxt  = pc_skip; // RQ4 RQ6
            cyc_nxt = req.next_two_word ? CYC_SKIP_TWO : CYC_SKIP_ONE; // RQ4 RQ6
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // program counter
   always_ff @(posedge clock) begin
      if (rst) begin
         pc_r <= PC_RST;
      end else if (accept) begin
         pc_r <= pc_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // status flags; an executing op wins over a software write
   always_ff @(posedge clock) begin
      if (rst) begin
         flags_r <= FLAGS_RST;
      end else if (accept) begin
         flags_r <= flags_nxt;
      end else if (reg_wr && reg_addr == ADDR_FLAGS) begin
         flags_r <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////
   // occupancy counter
   always_ff @(posedge clock) begin
      if (rst) begin
         left_r     <= 2'h0;
         last_cyc_r <= 2'h0;
      end else if (accept) begin
         left_r     <= cyc_nxt - 2'h1;
         last_cyc_r <= cyc_nxt;
      end else if (left_r != 2'h0) begin
         left_r <= left_r - 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////
   // result and stack push
   always_ff @(posedge clock) begin
      if (rst) begin
         res_r       <= '0;
         push_r      <= 1'b0;
         push_addr_r <= PC_RST;
      end else begin
         res_r  <= accept ? res_nxt : '0;
         push_r <= accept && push_nxt;
         if (accept && push_nxt) begin
            push_addr_r <= pc_seq; // RQ5
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // register port
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_r <= CTRL_RST;
      end else if (reg_wr && reg_addr == ADDR_CTRL) begin
         ctrl_r <= {7'h00, reg_wdata[CTRL_EN]};
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ADDR_FLAGS: rdata_r <= flags_r;
            ADDR_CTRL: rdata_r <= ctrl_r;
            ADDR_STAT: rdata_r <= {2'h0, last_cyc_r, left_r, 1'b0, left_r != 2'h0};
            default: rdata_r <= 8'h00;
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs
   assign res        = res_r;
   assign pc         = pc_r;
   assign flags      = flags_r;
   assign push_valid = push_r;
   assign push_addr  = push_addr_r;
   assign reg_rdata  = rdata_r;

endmodule : exec_unit

`default_nettype wire

// ---- tb/exec_unit_chk.sv ----
// checker for the execute stage, ports of exec_unit only
// assumes the register port keeps ctrl enable set
`timescale 1ns/1ps
`default_nettype none
module exec_unit_chk import exec_pkg::*; (
   input wire logic                clock,
   input wire logic                rst,
   input wire logic                req_valid,
   input wire exec_req_s           req,
   input wire logic                req_ready,
   input wire exec_res_s           res,
   input wire logic [PC_W-1:0]     pc,
   input wire logic [7:0]          flags,
   input wire logic                push_valid,
   input wire logic [PC_W-1:0]     push_addr
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   wire acc = req_valid && req_ready;
   a_word_spacing: assert property (acc && req.op == word_plus_imm_op |=> !req_ready ##1 req_ready)
      else $error("word add spacing wrong");
   a_and_keep: assert property (acc && req.op == and_imm_op |=> res.data[7:0] == $past(req.rd_lo & req.imm)
      && flags[FLAG_C] == $past(flags[FLAG_C]) && flags[FLAG_H] == $past(flags[FLAG_H]) && req_ready)
      else $error("and immediate result or flags wrong");
   a_product_pair: assert property (acc && req.op == signed_unsigned_product_op |=> res.wr_prod && !req_ready
      && res.data == $past(16'($signed({{8{req.rd_lo[7]}}, req.rd_lo}) * $signed({8'h00, req.rr})))
      && flags[FLAG_C] == res.data[15])
      else $error("product wrong");
   a_skip_equal: assert property (acc && req.op == compare_skip_equal_op |=> flags == $past(flags)
      && pc == $past(pc) + ($past(req.rd_lo == req.rr) ? ($past(req.next_two_word) ? 22'h3 : 22'h2) : 22'h1))
      else $error("compare skip wrong");
   a_call_jump: assert property (acc && req.op == indirect_call_op |=> (push_valid && !req_ready
      && push_addr == $past(pc) + 22'h1 && pc == {6'h00, $past(req.z_ptr)}) ##1 !req_ready)
      else $error("indirect call wrong");
   a_io_skip: assert property (acc && req.op == skip_io_bit_clear_op |=> flags == $past(flags)
      && pc == $past(pc) + ($past(req.io_val[req.io_bit]) ? 22'h1 : ($past(req.next_two_word) ? 22'h3 : 22'h2)))
      else $error("io bit skip wrong");
   a_ge_branch: assert property (acc && req.op == branch_signed_ge_op |=> flags == $past(flags)
      && pc == $past(pc) + 22'h1 + ($past(flags[FLAG_N] ^ flags[FLAG_V]) ? 22'h0
      : {{15{$past(req.rel[6])}}, $past(req.rel)}))
      else $error("signed ge branch wrong");
   a_nov_branch: assert property (acc && req.op == branch_no_overflow_op |=> flags == $past(flags)
      && pc == $past(pc) + 22'h1 + ($past(flags[FLAG_V]) ? 22'h0 : {{15{$past(req.rel[6])}}, $past(req.rel)}))
      else $error("no overflow branch wrong");
   a_sign_flag: assert property (acc && (req.op == word_plus_imm_op || req.op == and_imm_op)
      |=> flags[FLAG_S] == (flags[FLAG_N] ^ flags[FLAG_V]))
      else $error("sign flag wrong");
endmodule : exec_unit_chk
bind exec_unit exec_unit_chk i_chk (.clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
   .req_ready(req_ready), .res(res), .pc(pc), .flags(flags), .push_valid(push_valid), .push_addr(push_addr));
`default_nettype wire

// ---- tb/prog_side_model.sv ----
// far side: product pair R1:R0 and top of the return stack
// assumes results arrive as one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module prog_side_model import exec_pkg::*; (
   input wire logic                clock,
   input wire logic                rst,
   input wire exec_res_s           res,
   input wire logic                push_valid,
   input wire logic [PC_W-1:0]     push_addr,
   output logic [15:0]             prod_pair,
   output logic [PC_W-1:0]         ret_top
);
   always_ff @(posedge clock) begin
      if (rst) prod_pair <= 16'h0000;
      else if (res.valid && res.wr_prod) prod_pair <= res.data;
   end
   always_ff @(posedge clock) begin
      if (rst) ret_top <= '0;
      else if (push_valid) ret_top <= push_addr;
   end
endmodule : prog_side_model
`default_nettype wire

// ---- tb/tb.sv ----
// testbench for exec_unit with far-side model
// assumes register port at 0x00 flags, 0x01 ctrl
`timescale 1ns/1ps
`default_nettype none
module tb;
   import exec_pkg::*;
   logic                clock, rst, req_valid, req_ready, reg_wr, reg_rd, push_valid;
   exec_req_s           req;
   exec_res_s           res;
   logic [PC_W-1:0]     pc, push_addr, ret_top;
   logic [7:0]          flags, reg_addr, reg_wdata, reg_rdata, d;
   logic [15:0]         prod;
   int                  fail_count, n_tests;
   exec_unit i_dut (.clock(clock), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .res(res), .pc(pc), .flags(flags), .push_valid(push_valid), .push_addr(push_addr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   prog_side_model i_far (.clock(clock), .rst(rst), .res(res), .push_valid(push_valid),
      .push_addr(push_addr), .prod_pair(prod), .ret_top(ret_top));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   //////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [21:0] e, input logic [21:0] g);
      n_tests++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      d = reg_rdata;
   endtask : rd
   task automatic go(input exec_op_e o, input logic [7:0] lo, hi, rr, imm, input logic [6:0] rel,
                     input logic [15:0] z, input logic [7:0] iov, input logic [2:0] b, input logic two);
      @(posedge clock);
      req <= '{o, lo, hi, rr, imm, rel, z, iov, b, two};
      req_valid <= 1'b1;
      @(negedge clock);
      for (int i = 0; i < 8 && req_ready !== 1'b1; i++) @(negedge clock);
      @(posedge clock);
      req_valid <= 1'b0;
      @(negedge clock);
   endtask : go
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   //////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      fail_count++;
      end_sim;
   end
   initial begin
      rst = 1'b1; req_valid = 1'b0; req = '0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rd(8'h01); chk("ctrl", 22'h01, 22'(d));
      rd(8'h7F); chk("unmapped", 22'h00, 22'(d));
      wr(8'h00, 8'h21);
      go(and_imm_op, 8'hF0, 8'h00, 8'h00, 8'h8F, 7'h00, 16'h0000, 8'h00, 3'h0, 1'b0);
      chk("and data", 22'h80, 22'(res.data));
      chk("and flags", 22'h35, 22'(flags));
      go(word_plus_imm_op, 8'hFF, 8'hFF, 8'h00, 8'h01, 7'h00, 16'h0000, 8'h00, 3'h0, 1'b0);
      chk("word data", 22'h0000, 22'(res.data));
      chk("word flags", 22'h23, 22'(flags));
      go(signed_unsigned_product_op, 8'hFF, 8'h00, 8'h02, 8'h00, 7'h00, 16'h0000, 8'h00, 3'h0, 1'b0);
      chk("product flags", 22'h21, 22'(flags));
      @(negedge clock);
      chk("product pair", 22'hFFFE, 22'(prod));
      $display("test arithmetic done");
      go(compare_skip_equal_op, 8'h5A, 8'h00, 8'h5A, 8'h00, 7'h00, 16'h0000, 8'h00, 3'h0, 1'b1);
      chk("skip pc", 22'h6, pc);
      go(compare_skip_equal_op, 8'h5A, 8'h00, 8'h5B, 8'h00, 7'h00, 16'h0000, 8'h00, 3'h0, 1'b1);
      chk("noskip pc", 22'h7, pc);
      go(skip_io_bit_clear_op, 8'h00, 8'h00, 8'h00, 8'h00, 7'h00, 16'h0000, 8'hFB, 3'h2, 1'b0);
      chk("io skip pc", 22'h9, pc);
      go(skip_io_bit_clear_op, 8'h00, 8'h00, 8'h00, 8'h00, 7'h00, 16'h0000, 8'hFB, 3'h0, 1'b0);
      chk("io noskip pc", 22'hA, pc);
      chk("skip flags", 22'h21, 22'(flags));
      go(branch_no_overflow_op, 8'h00, 8'h00, 8'h00, 8'h00, 7'h7E, 16'h0000, 8'h00, 3'h0, 1'b0);
      chk("nov taken pc", 22'h9, pc);
      wr(8'h00, 8'h08);
      go(branch_no_overflow_op, 8'h00, 8'h00, 8'h00, 8'h00, 7'h7E, 16'h0000, 8'h00, 3'h0, 1'b0);
      chk("nov not pc", 22'hA, pc);
      go(branch_signed_ge_op, 8'h00, 8'h00, 8'h00, 8'h00, 7'h05, 16'h0000, 8'h00, 3'h0, 1'b0);
      chk("ge not pc", 22'hB, pc);
      wr(8'h00, 8'h0C);
      go(branch_signed_ge_op, 8'h00, 8'h00, 8'h00, 8'h00, 7'h05, 16'h0000, 8'h00, 3'h0, 1'b0);
      chk("ge taken pc", 22'h11, pc);
      go(indirect_call_op, 8'h00, 8'h00, 8'h00, 8'h00, 7'h00, 16'h1234, 8'h00, 3'h0, 1'b0);
      chk("call pc", 22'h001234, pc);
      @(negedge clock);
      chk("call return", 22'h12, ret_top);
      chk("call flags", 22'h0C, 22'(flags));
      rd(8'h00);
      chk("flags read", 22'h0C, 22'(d));
      rd(8'h02);
      chk("status read", 22'h30, 22'(d));
      wr(8'h01, 8'h00);
      @(negedge clock);
      chk("ready off", 22'h0, 22'(req_ready));
      wr(8'h01, 8'h01);
      go(op_nop, 8'h00, 8'h00, 8'h00, 8'h00, 7'h00, 16'h0000, 8'h00, 3'h0, 1'b0);
      chk("nop pc", 22'h001235, pc);
      $display("test flow done");
      end_sim;
   end
endmodule : tb
`default_nettype wire
